//--- llra_top.sv
// logical and transport layer: tx build, arbitration, rx routing, csrs
module llra_top #(
  parameter int  NPORT          = 4,     // transmit ports, 0..NRSP-1 responses
  parameter int  NRSP           = 2,     // ports carrying responses only
  parameter bit  LARGE_SYS      = 1'b0,  // 16-bit ids
  parameter bit  PERMIT_RST     = 1'b1,  // initiator permission at reset
  parameter bit  MAINT_PORT_EN  = 1'b1,  // maintenance port built
  parameter bit  WIN_DEC_EN     = 1'b1,  // window decoding built
  parameter bit  SPLIT_INIT     = 1'b0,  // split read/write initiator ports
  parameter logic [5:0] WMARK   = 6'h18  // buffer fill watermark
) (
  input  wire logic              SYS_CLK_I,     // core clock
  input  wire logic              RST_I,         // synchronous reset
  // transmit ports
  input  wire logic [NPORT-1:0]  TX_VALID_I,    // port has a header
  input  wire logic [NPORT*32-1:0] TX_TUSER_I,  // {src,dst} per port
  input  wire logic [NPORT*8-1:0] TX_HDR_I,     // {ftype,ttype} per port
  output      logic [NPORT-1:0]  TX_READY_O,    // header taken
  // built packet toward the buffer
  output      logic              PKT_VALID_O,   // header valid
  input  wire logic              PKT_READY_I,   // buffer accepts
  output      logic [15:0]       PKT_SRC_O,     // source id
  output      logic [15:0]       PKT_DST_O,     // destination id
  output      logic [1:0]        PKT_TT_O,      // transport type
  output      logic [7:0]        PKT_HDR_O,     // {ftype,ttype}
  input  wire logic [5:0]        BUF_FILL_I,    // buffer occupancy
  // receive header
  input  wire logic              RX_VALID_I,    // header strobe
  input  wire logic [3:0]        RX_FTYPE_I,    // class
  input  wire logic [3:0]        RX_TTYPE_I,    // transaction type
  input  wire logic [3:0]        RX_SIZE_I,     // size-1
  input  wire logic [33:0]       RX_ADDR_I,     // address
  input  wire logic [31:0]       RX_TUSER_I,    // {src,dst}
  output      logic              RX_VALID_O,    // route valid
  output      logic [2:0]        RX_DST_O,      // llra_dst_t code
  output      logic [31:0]       RX_TUSER_O,    // ids passed through
  // maintenance response and configuration access
  input  wire logic              CFG_WE_I,      // register write
  input  wire logic [23:0]       CFG_ADDR_I,    // register offset
  input  wire logic [31:0]       CFG_WDATA_I,   // write data
  output      logic [31:0]       CFG_RDATA_O,   // read data
  output      logic [31:0]       MNT_RSP_TUSER_O, // swapped ids
  // status
  output      logic [15:0]       LOCAL_ID_O,    // local id
  output      logic [23:0]       RSP_TIMEOUT_O, // time-out value
  output      logic              RSP_ONLY_O     // response-only
);

  // ----------------------------------------------------------------
  // every check below runs on the core clock, off during reset
  // ----------------------------------------------------------------
  default clocking chk_cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (RST_I);

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [31:0] base_id_q;   // base id register
  logic [9:0]  win_q;       // window field
  logic [31:0] tmo_q;       // response time-out register
  logic        permit_q;    // initiator permission

  // writes by offset; permission reset from build option
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      base_id_q <= llra_pkg::BASE_ID_RST;
      win_q     <= llra_pkg::CFG_WIN_RST;
      tmo_q     <= llra_pkg::PORT_TMO_RST;
      permit_q  <= PERMIT_RST;
    end
    else if (CFG_WE_I)
    begin
      case (CFG_ADDR_I)
        llra_pkg::BASE_ID_OFS:  base_id_q <= CFG_WDATA_I;
        llra_pkg::CFG_WIN_OFS:
          win_q <= CFG_WDATA_I[llra_pkg::WIN_FLD_LO +: 10];
        llra_pkg::PORT_TMO_OFS: tmo_q <= CFG_WDATA_I;
        llra_pkg::PORT_GEN_OFS:
          permit_q <= CFG_WDATA_I[llra_pkg::PERMIT_BIT];
        default: ;
      endcase
    end
  end

  // read mux, unmapped reads return zero
  always_comb
  begin
    case (CFG_ADDR_I)
      llra_pkg::BASE_ID_OFS:  CFG_RDATA_O = base_id_q;
      llra_pkg::CFG_WIN_OFS:
        CFG_RDATA_O = {1'b0, win_q, 21'h000000};
      llra_pkg::PORT_TMO_OFS: CFG_RDATA_O = tmo_q;
      llra_pkg::PORT_GEN_OFS:
        CFG_RDATA_O = {1'b0, permit_q, 30'h00000000};
      default:                CFG_RDATA_O = 32'h00000000;
    endcase
  end

  // local id: small ids right-justified into 16 bits
  always_comb
  begin
    if (LARGE_SYS)
      LOCAL_ID_O = base_id_q[15:0];
    else
      LOCAL_ID_O = {8'h00, base_id_q[llra_pkg::SMALL_ID_LO +: 8]};
  end

  // low byte of the register is reserved, not part of the count
  assign RSP_TIMEOUT_O = tmo_q[31:8];

  // ----------------------------------------------------------------
  // response-only gate
  // ----------------------------------------------------------------
  always_comb
  begin
    RSP_ONLY_O = !permit_q || (BUF_FILL_I > WMARK);
  end

  // ----------------------------------------------------------------
  // transmit arbitration
  // ----------------------------------------------------------------
  logic [NPORT-1:0] req;  // eligible requests
  logic [NPORT-1:0] gnt;  // one-hot grant
  logic             busy_q; // holding a packet for the buffer
  logic             take;   // a header taken this cycle

  // mask initiator ports while response-only; response ports always compete
  always_comb
  begin
    req = TX_VALID_I;
    if (RSP_ONLY_O)
      for (int p = NRSP; p < NPORT; p++)
        req[p] = 1'b0;
  end

  // single packet register: no new take until it drains
  assign take       = !busy_q && (req != '0);
  assign TX_READY_O = busy_q ? '0 : gnt;

  // arbiter keeps its own age order of the ports
  llra_arb #(
    .N (NPORT)
  ) u_arb (
    .SYS_CLK_I (SYS_CLK_I),
    .RST_I     (RST_I),
    .req_i     (req),
    .adv_i     (take),
    .gnt_o     (gnt)
  );

  // capture granted header; src from tuser upper half
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      busy_q    <= 1'b0;
      PKT_SRC_O <= 16'h0000;
      PKT_DST_O <= 16'h0000;
      PKT_HDR_O <= 8'h00;
      PKT_TT_O  <= llra_pkg::TT_SMALL;
    end
    else if (take)
    begin
      busy_q <= 1'b1;
      for (int p = 0; p < NPORT; p++)
        if (gnt[p])
        begin
          PKT_SRC_O <= TX_TUSER_I[p*32+16 +: 16];
          PKT_DST_O <= TX_TUSER_I[p*32 +: 16];
          PKT_HDR_O <= TX_HDR_I[p*8 +: 8];
        end
      PKT_TT_O <= LARGE_SYS ? llra_pkg::TT_LARGE
                            : llra_pkg::TT_SMALL;
    end
    else if (busy_q && PKT_READY_I)
      busy_q <= 1'b0;
  end

  // valid is the holding flag itself, no extra stage
  assign PKT_VALID_O = busy_q;

  // ----------------------------------------------------------------
  // receive routing
  // ----------------------------------------------------------------
  llra_pkg::llra_dst_t dst; // routing decision

  // routing is purely combinational on the header
  llra_rx_route #(
    .MAINT_PORT_EN (MAINT_PORT_EN),
    .WIN_DEC_EN    (WIN_DEC_EN),
    .SPLIT_INIT    (SPLIT_INIT)
  ) u_route (
    .ftype_i (RX_FTYPE_I),
    .ttype_i (RX_TTYPE_I),
    .size_i  (RX_SIZE_I),
    .addr_i  (RX_ADDR_I),
    .win_i   (win_q),
    .dst_o   (dst)
  );

  // register the decision; maintenance responses swap ids
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      RX_VALID_O      <= 1'b0;
      RX_DST_O        <= 3'h0;
      RX_TUSER_O      <= 32'h00000000;
      MNT_RSP_TUSER_O <= 32'h00000000;
    end
    else
    begin
      RX_VALID_O <= RX_VALID_I; // every header strobed out, whatever its route
      if (RX_VALID_I)
      begin
        RX_DST_O        <= 3'(dst);
        RX_TUSER_O      <= RX_TUSER_I;
        MNT_RSP_TUSER_O <= {RX_TUSER_I[15:0], RX_TUSER_I[31:16]};
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // ----------------------------------------------------------------
  // transmit side: gating, grant shape and packet build
  // ----------------------------------------------------------------
  rsp_only_gate_a : assert property (
    RSP_ONLY_O |-> (TX_READY_O[NPORT-1:NRSP] == '0))
    else $error("initiator port granted while response-only");

  rsp_port_open_a : assert property (
    (RSP_ONLY_O && !PKT_VALID_O && TX_VALID_I[NRSP-1:0] != '0)
      |-> (TX_READY_O != '0))
    else $error("response port starved while response-only");

  permit_gate_a : assert property (
    !permit_q |-> RSP_ONLY_O)
    else $error("response-only not raised without permission");

  grant_onehot_a : assert property (
    $onehot0(TX_READY_O))
    else $error("more than one transmit port granted");

  grant_valid_a : assert property (
    (TX_READY_O & ~TX_VALID_I) == '0)
    else $error("grant given to a port without a header");

  // one packet register, so a new take waits for it to drain
  busy_refuse_a : assert property (
    PKT_VALID_O |-> (TX_READY_O == '0))
    else $error("header taken while packet still pending");

  src_id_take_a : assert property (
    (take && gnt[0]) |=> (PKT_SRC_O == $past(TX_TUSER_I[31:16])))
    else $error("source id not from tuser upper half");

  tt_field_a : assert property (
    PKT_VALID_O |-> (PKT_TT_O == (LARGE_SYS ? 2'h1 : 2'h0)))
    else $error("transport type wrong for system size");

  hold_pkt_a : assert property (
    (PKT_VALID_O && !PKT_READY_I)
      |=> (PKT_VALID_O && $stable(PKT_SRC_O) && $stable(PKT_DST_O)))
    else $error("packet changed while stalled");

  // ----------------------------------------------------------------
  // configuration side: register writes reach their registers and outputs
  // ----------------------------------------------------------------
  local_id_a : assert property (
    (CFG_WE_I && CFG_ADDR_I == llra_pkg::BASE_ID_OFS)
      |=> (LOCAL_ID_O == (LARGE_SYS ? $past(CFG_WDATA_I[15:0])
                          : {8'h00, $past(CFG_WDATA_I[23:16])})))
    else $error("local id does not follow base id register");

  timeout_follow_a : assert property (
    (CFG_WE_I && CFG_ADDR_I == llra_pkg::PORT_TMO_OFS)
      |=> (RSP_TIMEOUT_O == $past(CFG_WDATA_I[31:8])))
    else $error("time-out output does not follow register");

  permit_write_a : assert property (
    (CFG_WE_I && CFG_ADDR_I == llra_pkg::PORT_GEN_OFS)
      |=> (permit_q == $past(CFG_WDATA_I[30])))
    else $error("initiator permission not writable");

  window_write_a : assert property (
    (CFG_WE_I && CFG_ADDR_I == llra_pkg::CFG_WIN_OFS)
      |=> (win_q == $past(CFG_WDATA_I[30:21])))
    else $error("window field not taken from bits 30:21");

  // ----------------------------------------------------------------
  // receive side: every header strobed out, window decode steers
  // ----------------------------------------------------------------
  swap_ids_a : assert property (
    RX_VALID_I |=> (MNT_RSP_TUSER_O
                    == {$past(RX_TUSER_I[15:0]), $past(RX_TUSER_I[31:16])}))
    else $error("maintenance response ids not swapped");

  rx_no_drop_a : assert property (
    RX_VALID_I |=> RX_VALID_O)
    else $error("received packet not delivered");

  rx_ids_pass_a : assert property (
    RX_VALID_I |=> (RX_TUSER_O == $past(RX_TUSER_I)))
    else $error("received ids not passed through");

  swrite_io_a : assert property (
    (RX_VALID_I && RX_FTYPE_I == llra_pkg::FT_SWRITE)
      |=> (RX_DST_O == 3'(llra_pkg::DST_IO)))
    else $error("streaming write not sent to ordinary port");

  window_maint_a : assert property (
    (RX_VALID_I && WIN_DEC_EN && MAINT_PORT_EN
     && RX_FTYPE_I == llra_pkg::FT_NREAD && RX_SIZE_I == llra_pkg::SIZE_WORD
     && RX_ADDR_I[33:24] == win_q)
      |=> (RX_DST_O == 3'(llra_pkg::DST_MAINT)))
    else $error("window hit not steered to maintenance port");

  window_rd_err_a : assert property (
    (RX_VALID_I && WIN_DEC_EN && MAINT_PORT_EN
     && RX_FTYPE_I == llra_pkg::FT_NREAD && RX_SIZE_I != llra_pkg::SIZE_WORD
     && RX_ADDR_I[33:24] == win_q)
      |=> (RX_DST_O == 3'(llra_pkg::DST_ERR_RESP)))
    else $error("odd-sized window read not answered with error");

  window_wr_drop_a : assert property (
    (RX_VALID_I && WIN_DEC_EN && MAINT_PORT_EN
     && RX_FTYPE_I == llra_pkg::FT_WRITE && RX_SIZE_I != llra_pkg::SIZE_WORD
     && RX_TTYPE_I == llra_pkg::TT_NWRITE_R && RX_ADDR_I[33:24] == win_q)
      |=> (RX_DST_O == 3'(llra_pkg::DST_DROP_ERR)))
    else $error("odd-sized acknowledged window write not refused");

  window_miss_a : assert property (
    (RX_VALID_I && RX_FTYPE_I == llra_pkg::FT_NREAD
     && RX_ADDR_I[33:24] != win_q)
      |=> (RX_DST_O == 3'(llra_pkg::DST_IO)))
    else $error("read outside window not sent to ordinary port");

  nodata_route_a : assert property (
    (RX_VALID_I && RX_FTYPE_I == llra_pkg::FT_RESP && !SPLIT_INIT)
      |=> (RX_DST_O == 3'(llra_pkg::DST_IO)))
    else $error("response not sent to ordinary port");

endmodule : llra_top

//--- llra_pkg.sv
// package of constants and types for the logical layer routing arbiter
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
package llra_pkg;

  // ----------------------------------------------------------------
  // register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [23:0] BASE_ID_OFS     = 24'h000060; // base id register
  localparam logic [23:0] CFG_WIN_OFS     = 24'h00005C; // window base register
  localparam logic [23:0] PORT_TMO_OFS    = 24'h000120; // response time-out
  localparam logic [23:0] PORT_GEN_OFS    = 24'h00013C; // port general control
  localparam logic [31:0] BASE_ID_RST     = 32'h00FFFFFF; // base id after reset
  localparam logic [9:0]  CFG_WIN_RST     = 10'h3FF;    // window field reset
  localparam logic [31:0] PORT_TMO_RST    = 32'hFFFFFF00; // time-out after reset

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int          WIN_FLD_LO      = 21;  // window field low bit
  localparam int          ADDR_CMP_LO     = 24;  // compared address low bit
  localparam int          SMALL_ID_LO     = 16;  // small base id low bit
  localparam int          PERMIT_BIT      = 30;  // initiator permission bit

  // ----------------------------------------------------------------
  // packet encodings
  // ----------------------------------------------------------------
  localparam logic [1:0]  TT_SMALL        = 2'h0; // small system tt
  localparam logic [1:0]  TT_LARGE        = 2'h1; // large system tt
  localparam logic [3:0]  FT_NREAD        = 4'h2; // request class
  localparam logic [3:0]  FT_WRITE        = 4'h5; // write class
  localparam logic [3:0]  FT_SWRITE       = 4'h6; // streaming write class
  localparam logic [3:0]  FT_MAINT        = 4'h8; // maintenance class
  localparam logic [3:0]  FT_RESP         = 4'hD; // response class
  localparam logic [3:0]  TT_NWRITE_R     = 4'h5; // acknowledged write
  localparam logic [3:0]  TT_RESP_NODATA  = 4'h0; // response without data
  localparam logic [3:0]  SIZE_WORD       = 4'h3; // size-1 for 32 bits

  // receive destinations
  typedef enum logic [2:0] {
    DST_IO,        // ordinary I/O port
    DST_MAINT,     // maintenance port
    DST_WR_RESP,   // write response port
    DST_ERR_RESP,  // local error response, nothing delivered
    DST_DROP_ERR   // dropped write that still answers with error
  } llra_dst_t;

endpackage : llra_pkg

//--- llra_rx_route.sv
// receive routing decision for one packet header
module llra_rx_route #(
  parameter bit MAINT_PORT_EN = 1'b1, // maintenance port built
  parameter bit WIN_DEC_EN    = 1'b1, // window decoding built
  parameter bit SPLIT_INIT    = 1'b0  // separate read/write initiator ports
) (
  input  wire logic [3:0]  ftype_i,   // packet class
  input  wire logic [3:0]  ttype_i,   // transaction type
  input  wire logic [3:0]  size_i,    // size-1 field
  input  wire logic [33:0] addr_i,    // 34-bit transaction address
  input  wire logic [9:0]  win_i,     // window comparison field
  output      llra_pkg::llra_dst_t dst_o // chosen destination
);

  // ----------------------------------------------------------------
  // window hit and destination
  // ----------------------------------------------------------------
  logic hit; // address inside configuration window

  // swrite never checked, so hit needs the class too
  always_comb
  begin
    hit = WIN_DEC_EN
          && (addr_i[33:llra_pkg::ADDR_CMP_LO] == win_i)
          && (ftype_i != llra_pkg::FT_SWRITE)
          && (ftype_i != llra_pkg::FT_MAINT);
  end

  always_comb
  begin
    dst_o = llra_pkg::DST_IO; // default: deliver, never discard
    if (ftype_i == llra_pkg::FT_RESP)
    begin
      if (SPLIT_INIT && ttype_i == llra_pkg::TT_RESP_NODATA)
        dst_o = llra_pkg::DST_WR_RESP;
    end
    else if (hit && MAINT_PORT_EN)
    begin
      if (size_i == llra_pkg::SIZE_WORD)
        dst_o = llra_pkg::DST_MAINT;
      else if (ftype_i == llra_pkg::FT_NREAD)
        dst_o = llra_pkg::DST_ERR_RESP;
      else if (ftype_i == llra_pkg::FT_WRITE
               && ttype_i == llra_pkg::TT_NWRITE_R)
        dst_o = llra_pkg::DST_DROP_ERR;
      else
        dst_o = llra_pkg::DST_ERR_RESP; // silent drop shares no-deliver
    end
  end

endmodule : llra_rx_route

//--- llra_arb.sv
// least-recently-granted arbiter for the transmit ports
module llra_arb #(
  parameter int N = 4 // number of transmit ports
) (
  input  wire logic         SYS_CLK_I, // core clock
  input  wire logic         RST_I,     // synchronous reset
  input  wire logic [N-1:0] req_i,     // ports with a packet ready
  input  wire logic         adv_i,     // grant taken, update order
  output      logic [N-1:0] gnt_o      // one-hot grant
);

  // ----------------------------------------------------------------
  // age order: slot 0 is the port idle longest
  // ----------------------------------------------------------------
  logic [$clog2(N)-1:0] ord_q [N]; // port per slot
  int                   win;       // winning slot

  always_comb
  begin
    win   = N;
    gnt_o = '0;
    for (int s = N - 1; s >= 0; s--)
      if (req_i[ord_q[s]])
        win = s; // lowest slot requesting is oldest
    if (win < N)
      gnt_o[ord_q[win]] = 1'b1;
  end

  // move winner to the back of the queue
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      for (int s = 0; s < N; s++)
        ord_q[s] <= $clog2(N)'(s);
    end
    else if (adv_i && win < N)
    begin
      for (int s = 0; s < N - 1; s++)
        if (s >= win)
          ord_q[s] <= ord_q[s+1];
      ord_q[N-1] <= ord_q[win];
    end
  end

endmodule : llra_arb

//--- llra_user_model.sv
// user logic partner driving the transmit ports of the arbiter
module llra_user_model #(
  parameter int NPORT = 4 // transmit ports modelled
) (
  input  wire logic [0:0]          clk_i,   // core clock
  input  wire logic                rst_i,   // synchronous reset
  input  wire logic [NPORT-1:0]    go_i,    // bench asks for a header
  input  wire logic [NPORT*32-1:0] tuser_i, // ids per port
  input  wire logic [NPORT-1:0]    ready_i, // header taken
  output      logic [NPORT-1:0]    valid_o, // header offered
  output      logic [NPORT*32-1:0] tuser_o  // ids while offered
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [NPORT*32-1:0] held_q; // ids latched at the request

  // ----------------------------------------------------------
  // one header per port in flight, held until taken
  // ----------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    for (int p = 0; p < NPORT; p++)
    begin
      if (rst_i)
        valid_o[p] <= 1'b0;
      else if (valid_o[p] && ready_i[p])
        valid_o[p] <= 1'b0;
      else if (go_i[p] && !valid_o[p])
      begin
        // no priority field here, so no request uses the top level
        valid_o[p] <= 1'b1;
        held_q[p*32 +: 32] <= tuser_i[p*32 +: 32];
      end
    end
  end

  // released ids show the inverse so a stale copy cannot pass
  always_comb
  begin
    for (int p = 0; p < NPORT; p++)
      tuser_o[p*32 +: 32] = valid_o[p] ? held_q[p*32 +: 32]
                                       : ~held_q[p*32 +: 32];
  end
endmodule : llra_user_model

//--- tb_top.sv
// self-checking testbench for the logical layer routing arbiter
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic         clk, rst, pkt_ready, rx_valid, cfg_we;   // bench drives
  logic         pkt_valid, rx_valid_o, rsp_only;         // design drives
  logic [3:0]   go, tx_valid, tx_ready, rx_ft, rx_tt, rx_sz; // strobes
  logic [127:0] tx_tuser, src_tuser;                     // per-port ids
  logic [31:0]  tx_hdr, rx_tuser, rx_tuser_o, cfg_wdata; // data
  logic [31:0]  cfg_rdata, mnt_tuser, rd;                // read back
  logic [15:0]  pkt_src, pkt_dst, local_id;              // ids
  logic [23:0]  cfg_addr, tmo;                           // offsets
  logic [33:0]  rx_addr;                                 // rx address
  logic [7:0]   pkt_hdr;                                 // built header
  logic [5:0]   fill;                                    // buffer level
  logic [2:0]   rx_dst;                                  // route code
  logic [1:0]   pkt_tt;                                  // transport type
  int           error_cnt, comparisons;                  // tallies

  llra_top u_dut (.SYS_CLK_I(clk), .RST_I(rst), .TX_VALID_I(tx_valid),
    .TX_TUSER_I(tx_tuser), .TX_HDR_I(tx_hdr), .TX_READY_O(tx_ready),
    .PKT_VALID_O(pkt_valid), .PKT_READY_I(pkt_ready), .PKT_SRC_O(pkt_src),
    .PKT_DST_O(pkt_dst), .PKT_TT_O(pkt_tt), .PKT_HDR_O(pkt_hdr),
    .BUF_FILL_I(fill), .RX_VALID_I(rx_valid), .RX_FTYPE_I(rx_ft),
    .RX_TTYPE_I(rx_tt), .RX_SIZE_I(rx_sz), .RX_ADDR_I(rx_addr),
    .RX_TUSER_I(rx_tuser), .RX_VALID_O(rx_valid_o), .RX_DST_O(rx_dst),
    .RX_TUSER_O(rx_tuser_o), .CFG_WE_I(cfg_we), .CFG_ADDR_I(cfg_addr),
    .CFG_WDATA_I(cfg_wdata), .CFG_RDATA_O(cfg_rdata),
    .MNT_RSP_TUSER_O(mnt_tuser), .LOCAL_ID_O(local_id),
    .RSP_TIMEOUT_O(tmo), .RSP_ONLY_O(rsp_only));

  llra_user_model u_user (.clk_i(clk), .rst_i(rst), .go_i(go),
    .tuser_i(src_tuser), .ready_i(tx_ready), .valid_o(tx_valid),
    .tuser_o(tx_tuser));

  // ----------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------
  task automatic chk(input logic [63:0] got, exp, input string m);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk

  task automatic stop_test;
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task automatic cfg_wr(input logic [23:0] a, input logic [31:0] d);
    @(posedge clk);
    cfg_we <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_we <= 1'b0;
    #1;
  endtask : cfg_wr

  task automatic cfg_rd(input logic [23:0] a);
    @(posedge clk);
    cfg_addr <= a;
    @(posedge clk);
    #1 rd = cfg_rdata;
  endtask : cfg_rd

  // request headers on the ports in the mask for one edge
  task automatic send(input logic [3:0] m);
    @(posedge clk);
    go <= m;
    @(posedge clk);
    go <= 4'h0;
  endtask : send

  // wait for a built packet from port p, stall, then accept it
  task automatic drain(input int p, input int stall);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end while (!pkt_valid && n < 20);
    repeat (stall) @(posedge clk);
    #1 chk(pkt_valid, 1'b1, "packet not held");
    chk(pkt_src, 16'h00A0 + p[15:0], "source id or grant order");
    chk(pkt_dst, 16'h0055, "destination id");
    chk(pkt_tt, llra_pkg::TT_SMALL, "transport type");
    chk(pkt_hdr, tx_hdr[p*8 +: 8], "header");
    @(posedge clk);
    pkt_ready <= 1'b1;
    @(posedge clk);
    pkt_ready <= 1'b0;
  endtask : drain

  // one received header; route shows one cycle after the strobe
  task automatic rx(input logic [3:0] ft, tt, sz, input logic [33:0] a,
                    input logic [2:0] d);
    @(posedge clk);
    {rx_valid, rx_ft, rx_tt, rx_sz, rx_addr} <= {1'b1, ft, tt, sz, a};
    rx_tuser <= 32'h00770099;
    @(posedge clk);
    rx_valid <= 1'b0;
    #1 chk(rx_valid_o, 1'b1, "route strobe");
    chk(rx_dst, d, "route code");
    chk(rx_tuser_o, 32'h00770099, "ids passed");
    if (d == 3'h1)
      chk(mnt_tuser, 32'h00990077, "swapped ids");
  endtask : rx

  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task automatic t_regs;
    #1 chk(local_id, 16'h00FF, "local id at reset");
    chk(tmo, 24'hFFFFFF, "timeout at reset");
    chk(rsp_only, 1'b0, "permission at reset");
    cfg_rd(llra_pkg::CFG_WIN_OFS);
    chk(rd[30:21], 10'h3FF, "window reset");
    cfg_wr(llra_pkg::BASE_ID_OFS, 32'h00123456);
    chk(local_id, 16'h0012, "local id follows");
    cfg_wr(llra_pkg::PORT_TMO_OFS, 32'h00ABCD00);
    chk(tmo, 24'h00ABCD, "timeout follows");
  endtask : t_regs

  task automatic t_arb;
    send(4'h4);
    drain(2, 3);
    send(4'hF);
    drain(0, 0);
    drain(1, 0);
    drain(3, 1);
    drain(2, 0);
  endtask : t_arb

  task automatic t_rsp_only;
    @(posedge clk);
    fill <= 6'h19;
    #1 chk(rsp_only, 1'b1, "over watermark");
    send(4'hA);
    drain(1, 0);
    repeat (6) @(posedge clk);
    #1 chk(pkt_valid, 1'b0, "initiator refused");
    @(posedge clk);
    fill <= 6'h18;
    #1 chk(rsp_only, 1'b0, "at watermark");
    drain(3, 0);
    cfg_wr(llra_pkg::PORT_GEN_OFS, 32'h00000000);
    chk(rsp_only, 1'b1, "permission cleared");
    cfg_wr(llra_pkg::PORT_GEN_OFS, 32'h40000000);
    chk(rsp_only, 1'b0, "permission set");
  endtask : t_rsp_only

  task automatic t_route;
    rx(llra_pkg::FT_NREAD, 4'h4, 4'h3, 34'h3FF000010, 3'h1);
    rx(llra_pkg::FT_NREAD, 4'h4, 4'h7, 34'h3FF000010, 3'h3);
    rx(llra_pkg::FT_WRITE, 4'h5, 4'h1, 34'h3FFFFFFF0, 3'h4);
    rx(llra_pkg::FT_WRITE, 4'h4, 4'h1, 34'h3FFFFFFF0, 3'h3);
    rx(llra_pkg::FT_SWRITE, 4'h0, 4'h3, 34'h3FF000000, 3'h0);
    rx(llra_pkg::FT_NREAD, 4'h4, 4'h3, 34'h2FF000000, 3'h0);
    rx(llra_pkg::FT_RESP, 4'h0, 4'h0, 34'h000000000, 3'h0);
    cfg_wr(llra_pkg::CFG_WIN_OFS, 32'h80300000);
    rx(llra_pkg::FT_NREAD, 4'h4, 4'h3, 34'h001000000, 3'h1);
    rx(llra_pkg::FT_NREAD, 4'h4, 4'h3, 34'h3FF000000, 3'h0);
  endtask : t_route

  // ----------------------------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // whole run needs well under 2000 cycles
  initial
  begin
    #50000;
    error_cnt++;
    $display("watchdog expired");
    stop_test;
  end

  initial
  begin
    {rst, pkt_ready, rx_valid, cfg_we, go, fill} = {1'b1, 13'h0};
    {rx_ft, rx_tt, rx_sz, rx_addr, rx_tuser} = '0;
    {cfg_addr, cfg_wdata} = '0;
    tx_hdr = {llra_pkg::FT_WRITE, llra_pkg::TT_NWRITE_R,
              llra_pkg::FT_WRITE, llra_pkg::TT_NWRITE_R,
              llra_pkg::FT_RESP, llra_pkg::TT_RESP_NODATA,
              llra_pkg::FT_RESP, llra_pkg::TT_RESP_NODATA};
    for (int p = 0; p < 4; p++)
      src_tuser[p*32 +: 32] = {16'h00A0 + p[15:0], 16'h0055};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_arb;
    t_rsp_only;
    t_route;
    stop_test;
  end
endmodule : tb_top
